// >>> pio_pkg.sv
// Package for the parallel I/O port block: register indices, field
// positions, reset values and the packed carriers used at the ports.
// Assumes a 32-bit classic Wishbone register bus with byte addresses.
package pio_pkg;

    // Register indices; byte address is four times the index
    localparam logic [13:0] PIO_IDX_PORT_A_DATA = 14'h1000;
    localparam logic [13:0] PIO_IDX_PORT_A_DIR  = 14'h1001;
    localparam logic [13:0] PIO_IDX_PORT_B_DATA = 14'h1004;
    localparam logic [13:0] PIO_IDX_PORT_C_DATA = 14'h1006;
    localparam logic [13:0] PIO_IDX_PORT_C_DIR  = 14'h1007;
    localparam logic [13:0] PIO_IDX_PORT_D_DATA = 14'h1008;
    localparam logic [13:0] PIO_IDX_PORT_D_DIR  = 14'h1009;
    localparam logic [13:0] PIO_IDX_PORT_E_DATA = 14'h100a;
    localparam logic [13:0] PIO_IDX_CONTROL     = 14'h1010;

    // Control register fields
    localparam int PIO_CTL_CCS_BIT  = 0;
    localparam int PIO_CTL_PCOD_BIT = 1;

    // Reset values
    localparam logic [7:0] PIO_PORT_B_RST = 8'h00;
    localparam logic [7:0] PIO_DIR_RST    = 8'h00;
    localparam logic [5:0] PIO_PD_DIR_RST = 6'h00;
    localparam logic [1:0] PIO_CTL_RST    = 2'h0;

    // Port D pin positions
    localparam int PIO_PD_RXD  = 0;
    localparam int PIO_PD_TXD  = 1;
    localparam int PIO_PD_MISO = 2;
    localparam int PIO_PD_MOSI = 3;
    localparam int PIO_PD_SCK  = 4;
    localparam int PIO_PD_SS   = 5;

    // Pin levels arriving from the board
    typedef struct packed {
        logic [7:0] pa;
        logic [7:0] pc;
        logic [5:0] pd;
        logic [7:0] pe;
    } pio_pin_in_t;

    // Pin drive toward the board
    typedef struct packed {
        logic [7:0] pa;
        logic [7:0] pa_oe;
        logic [7:0] pb;
        logic [7:0] pc;
        logic [7:0] pc_oe;
        logic [5:0] pd;
        logic [5:0] pd_oe;
    } pio_pin_out_t;

    // Same-clock requests from timer, SPI, SCI and external bus logic
    typedef struct packed {
        logic [7:0]  oc_en;
        logic [7:0]  oc_val;
        logic        spi_en;
        logic        spi_master;
        logic        spi_od;
        logic [2:0]  spi_val;
        logic        sci_tx_en;
        logic        sci_tx_val;
        logic [15:8] ext_addr_hi;
        logic [7:0]  ext_data;
        logic        ext_write;
    } pio_periph_in_t;

endpackage

// >>> pio_ports.sv
// Parallel I/O ports A to E with a classic Wishbone register slave.
// Assumes pins and the mode strap are asynchronous, while timer, SPI,
// SCI and external bus requests come from logic on clk_i.
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps

module pio_ports (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [15:0]             wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic      [31:0]             wb_dat_o,
    output logic                         wb_ack_o,
    output logic                         wb_err_o,
    input  wire logic                    mode_expanded_i,
    input  wire pio_pkg::pio_pin_in_t    pins_i,
    output pio_pkg::pio_pin_out_t        pins_o,
    input  wire pio_pkg::pio_periph_in_t periph_i,
    input  wire logic                    tcc_write_i,
    output logic                         tcc_write_o,
    output logic [2:0]                   capture_o,
    output logic                         capture4_o,
    output logic                         pulse_accum_o,
    output logic                         spi_ss_o,
    output logic [2:0]                   spi_pin_o,
    output logic                         sci_rx_o,
    output logic [7:0]                   analog_pin_o
);

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    pio_pkg::pio_pin_in_t pin_meta_reg;
    pio_pkg::pio_pin_in_t pin_sync_reg;
    logic                 mode_meta_reg;
    logic                 mode_sync_reg;

    // Two stages; only the second stage is looked at by any logic
    always_ff @(posedge clk_i) begin
        pin_meta_reg  <= pins_i;
        pin_sync_reg  <= pin_meta_reg;
        mode_meta_reg <= mode_expanded_i;
        mode_sync_reg <= mode_meta_reg;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register state

    logic [7:0] pa_data_reg;
    logic [7:0] pa_dir_reg;
    logic [7:0] pb_data_reg;
    logic [7:0] pc_data_reg;
    logic [7:0] pc_dir_reg;
    logic [5:0] pd_data_reg;
    logic [5:0] pd_dir_reg;
    logic [1:0] ctl_reg;
    logic       ack_reg;
    logic       err_reg;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    ////////////////////////////////////////////////////////////////////////
    // Bus decode

    logic [13:0] idx;
    logic        req;
    logic        expanded;
    logic        hit_pa;
    logic        hit_pad;
    logic        hit_pb;
    logic        hit_pc;
    logic        hit_pcd;
    logic        hit_pd;
    logic        hit_pdd;
    logic        hit_pe;
    logic        hit_ctl;
    logic        mapped;
    logic        wr;
    logic [7:0]  wbyte;

    // Port B and C data vanish from the map in expanded modes
    assign idx      = wb_adr_i[15:2];
    assign req      = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
    assign expanded = mode_sync_reg;
    assign hit_pa   = (idx == pio_pkg::PIO_IDX_PORT_A_DATA);
    assign hit_pad  = (idx == pio_pkg::PIO_IDX_PORT_A_DIR);
    assign hit_pb   = (idx == pio_pkg::PIO_IDX_PORT_B_DATA) & ~expanded;
    assign hit_pc   = (idx == pio_pkg::PIO_IDX_PORT_C_DATA) & ~expanded;
    assign hit_pcd  = (idx == pio_pkg::PIO_IDX_PORT_C_DIR);
    assign hit_pd   = (idx == pio_pkg::PIO_IDX_PORT_D_DATA);
    assign hit_pdd  = (idx == pio_pkg::PIO_IDX_PORT_D_DIR);
    assign hit_pe   = (idx == pio_pkg::PIO_IDX_PORT_E_DATA);
    assign hit_ctl  = (idx == pio_pkg::PIO_IDX_CONTROL);
    assign mapped   = hit_pa | hit_pad | hit_pb | hit_pc | hit_pcd | hit_pd
                    | hit_pdd | hit_pe | hit_ctl;
    // Only the low byte lane carries register data
    assign wr       = req & mapped & wb_we_i & wb_sel_i[0];
    assign wbyte    = wb_dat_i[7:0];

    ////////////////////////////////////////////////////////////////////////
    // Effective directions and pin functions

    // Pin for inputs, latch for outputs
    function automatic logic [7:0] pio_mix(input logic [7:0] dir,
                                           input logic [7:0] latch,
                                           input logic [7:0] pin);
        return (dir & latch) | (~dir & pin);
    endfunction

    logic       ccs;
    logic       pc_od_eff;
    logic [7:0] pa_oc_en;
    logic [7:0] pa_out;
    logic [7:0] pc_out;
    logic [7:0] pc_drive;
    logic [5:0] pd_dir_eff;
    logic [5:0] pd_out;
    logic [2:0] spi_out_exp;
    logic       spi_on;

    assign ccs       = ctl_reg[pio_pkg::PIO_CTL_CCS_BIT];
    assign pc_od_eff = ctl_reg[pio_pkg::PIO_CTL_PCOD_BIT] & ~expanded;

    // Compare override on bit 3 only while it is the fifth compare
    assign pa_oc_en = periph_i.oc_en & {4'hf, ~ccs, 3'h7};
    assign pa_out   = (pa_oc_en & periph_i.oc_val) | (~pa_oc_en & pa_data_reg);

    // Expanded: data bus driven while the external cycle writes
    assign pc_out   = expanded ? periph_i.ext_data : pc_data_reg;
    assign pc_drive = expanded ? {8{periph_i.ext_write}} : pc_dir_reg;

    // Master drives SCK and MOSI, slave drives MISO
    assign spi_on      = periph_i.spi_en;
    assign spi_out_exp = periph_i.spi_master ? 3'h6 : 3'h1;

    always_comb begin
        pd_dir_eff = pd_dir_reg;
        pd_out     = pd_data_reg;
        if (periph_i.sci_tx_en) begin
            pd_dir_eff[pio_pkg::PIO_PD_TXD] = 1'b1;
            pd_out[pio_pkg::PIO_PD_TXD]     = periph_i.sci_tx_val;
        end
        if (spi_on) begin
            // Expected inputs forced, expected outputs still need the bit
            pd_dir_eff[4:2] = pd_dir_reg[4:2] & spi_out_exp;
            for (int i = 0; i < 3; i++) begin
                if (spi_out_exp[i]) begin
                    pd_out[pio_pkg::PIO_PD_MISO + i] = periph_i.spi_val[i];
                end
            end
            if (!periph_i.spi_master) begin
                pd_dir_eff[pio_pkg::PIO_PD_SS] = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive

    // Open-drain keeps the low-side driver only: a one floats the pin
    always_comb begin
        pins_o.pa    = pa_out;
        pins_o.pa_oe = pa_dir_reg | pa_oc_en;
        pins_o.pb    = expanded ? periph_i.ext_addr_hi : pb_data_reg;
        pins_o.pc    = pc_out;
        pins_o.pc_oe = pc_drive & ~({8{pc_od_eff}} & pc_out);
        pins_o.pd    = pd_out;
        pins_o.pd_oe = pd_dir_eff & ~({6{periph_i.spi_od}} & pd_out);
    end

    ////////////////////////////////////////////////////////////////////////
    // Peripheral-facing inputs

    // Captures see the pin, so latch writes on an output make edges
    assign capture_o     = pin_sync_reg.pa[2:0];
    assign capture4_o    = ccs & pin_sync_reg.pa[3];
    assign pulse_accum_o = pin_sync_reg.pa[7];
    assign tcc_write_o   = tcc_write_i & ~ccs;
    assign spi_ss_o      = pin_sync_reg.pd[pio_pkg::PIO_PD_SS];
    assign spi_pin_o     = pin_sync_reg.pd[4:2];
    assign sci_rx_o      = pin_sync_reg.pd[pio_pkg::PIO_PD_RXD];
    assign analog_pin_o  = pin_sync_reg.pe;

    ////////////////////////////////////////////////////////////////////////
    // Read mux

    always_comb begin
        rdata_next = 8'h00;
        if (hit_pa) begin
            rdata_next = pio_mix(pins_o.pa_oe, pa_out, pin_sync_reg.pa);
        end else if (hit_pad) begin
            rdata_next = pa_dir_reg;
        end else if (hit_pb) begin
            rdata_next = pb_data_reg;
        end else if (hit_pc) begin
            rdata_next = pio_mix(pc_dir_reg, pc_data_reg, pin_sync_reg.pc);
        end else if (hit_pcd) begin
            rdata_next = pc_dir_reg;
        end else if (hit_pd) begin
            rdata_next = pio_mix({2'h0, pd_dir_eff}, {2'h0, pd_out},
                                 {2'h0, pin_sync_reg.pd});
        end else if (hit_pdd) begin
            rdata_next = {2'h0, pd_dir_reg};
        end else if (hit_pe) begin
            // Reading during mixed-use sampling disturbs the converter
            rdata_next = pin_sync_reg.pe;
        end else if (hit_ctl) begin
            rdata_next = {6'h00, ctl_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait state, ack or err for one cycle

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            err_reg   <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            ack_reg   <= req & mapped;
            err_reg   <= req & ~mapped;
            rdata_reg <= req ? rdata_next : rdata_reg;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_err_o = err_reg;
    assign wb_dat_o = {24'h000000, rdata_reg};

    ////////////////////////////////////////////////////////////////////////
    // Data latches; inputs-at-reset latches follow the pin during reset

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_data_reg <= pin_sync_reg.pa;
            pc_data_reg <= pin_sync_reg.pc;
            pd_data_reg <= pin_sync_reg.pd;
            pb_data_reg <= pio_pkg::PIO_PORT_B_RST;
        end else begin
            pa_data_reg <= (wr & hit_pa) ? wbyte : pa_data_reg;
            pc_data_reg <= (wr & hit_pc) ? wbyte : pc_data_reg;
            pd_data_reg <= (wr & hit_pd) ? wbyte[5:0] : pd_data_reg;
            pb_data_reg <= (wr & hit_pb) ? wbyte : pb_data_reg;
        end
    end

    // Direction and control registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pa_dir_reg <= pio_pkg::PIO_DIR_RST;
            pc_dir_reg <= pio_pkg::PIO_DIR_RST;
            pd_dir_reg <= pio_pkg::PIO_PD_DIR_RST;
            ctl_reg    <= pio_pkg::PIO_CTL_RST;
        end else begin
            pa_dir_reg <= (wr & hit_pad) ? wbyte : pa_dir_reg;
            pc_dir_reg <= (wr & hit_pcd) ? wbyte : pc_dir_reg;
            pd_dir_reg <= (wr & hit_pdd) ? wbyte[5:0] : pd_dir_reg;
            ctl_reg    <= (wr & hit_ctl) ? wbyte[1:0] : ctl_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    property p_dir_reset;
        @(posedge clk_i) rst_i |=> (pd_dir_reg == 6'h00) && (pc_dir_reg == 8'h00);
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("direction registers not cleared by reset");

    property p_pb_reset;
        @(posedge clk_i) rst_i ##1 !rst_i && !expanded |-> pins_o.pb == 8'h00;
    endproperty
    a_pb_reset: assert property (p_pb_reset)
        else $error("port B output not zero after reset");

    property p_pb_addr;
        @(posedge clk_i) disable iff (rst_i)
            expanded |-> pins_o.pb == periph_i.ext_addr_hi;
    endproperty
    a_pb_addr: assert property (p_pb_addr)
        else $error("port B not carrying high address in expanded mode");

    property p_unmapped_err;
        @(posedge clk_i) disable iff (rst_i)
            req && expanded && idx == pio_pkg::PIO_IDX_PORT_C_DATA
            |=> wb_err_o && !wb_ack_o ##1 !wb_err_o;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("port C data not removed in expanded mode");

    property p_pcod_low;
        @(posedge clk_i) disable iff (rst_i)
            !expanded && ctl_reg[1] && pc_dir_reg[0] && !pc_data_reg[0]
            |-> pins_o.pc_oe[0] && !pins_o.pc[0];
    endproperty
    a_pcod_low: assert property (p_pcod_low)
        else $error("open-drain zero not driven low");

    property p_pcod_float;
        @(posedge clk_i) disable iff (rst_i)
            !expanded && ctl_reg[1] && pc_data_reg[7] |-> !pins_o.pc_oe[7];
    endproperty
    a_pcod_float: assert property (p_pcod_float)
        else $error("open-drain one still driven");

    property p_pcod_expanded;
        @(posedge clk_i) disable iff (rst_i)
            expanded && periph_i.ext_write |-> pins_o.pc_oe == 8'hff;
    endproperty
    a_pcod_expanded: assert property (p_pcod_expanded)
        else $error("open-drain acted in expanded mode");

    property p_ss_slave;
        @(posedge clk_i) disable iff (rst_i)
            spi_on && !periph_i.spi_master |-> !pins_o.pd_oe[5];
    endproperty
    a_ss_slave: assert property (p_ss_slave)
        else $error("slave select driven in slave mode");

    property p_spi_in_forced;
        @(posedge clk_i) disable iff (rst_i)
            spi_on && periph_i.spi_master |-> !pins_o.pd_oe[2];
    endproperty
    a_spi_in_forced: assert property (p_spi_in_forced)
        else $error("expected SPI input still driven");

    property p_spi_out_needs_dir;
        @(posedge clk_i) disable iff (rst_i)
            spi_on && !pd_dir_reg[4] |-> !pins_o.pd_oe[4];
    endproperty
    a_spi_out_needs_dir: assert property (p_spi_out_needs_dir)
        else $error("SPI output driven without direction bit");

    property p_tcc_block;
        @(posedge clk_i) disable iff (rst_i) ccs |-> !tcc_write_o;
    endproperty
    a_tcc_block: assert property (p_tcc_block)
        else $error("shared register write passed while capturing");

    property p_pai_follow;
        @(posedge clk_i) disable iff (rst_i)
            ##2 pulse_accum_o == $past(pins_i.pa[7], 2);
    endproperty
    a_pai_follow: assert property (p_pai_follow)
        else $error("pulse accumulator input not following pin");

    property p_write_pa;
        @(posedge clk_i) disable iff (rst_i)
            wr && hit_pa |=> pa_data_reg == $past(wbyte) ##1 wb_ack_o == 1'b0;
    endproperty
    a_write_pa: assert property (p_write_pa)
        else $error("port A latch write lost or ack held");

endmodule

// >>> pio_board.sv
// Board model for the parallel I/O pins: resolves every pin level.
// Assumes board sources on ports A and E and pull-ups on C and D.
`timescale 1ns/1ps
module pio_board (
    input  wire pio_pkg::pio_pin_out_t pins_o_i,
    input  wire logic [7:0]            src_pa_i,
    input  wire logic [7:0]            src_pc_i,
    input  wire logic [7:0]            src_pc_en_i,
    input  wire logic [7:0]            src_pe_i,
    output pio_pkg::pio_pin_in_t       pins_i_o
);
    ////////////////////////////////////////////////////////////////////////
    // Pulled-up lines float high when released, so open drain reads as one
    assign pins_i_o = '{
        pa: (pins_o_i.pa_oe & pins_o_i.pa) | (~pins_o_i.pa_oe & src_pa_i),
        pc: (pins_o_i.pc_oe & pins_o_i.pc) | (~pins_o_i.pc_oe
            & ((src_pc_en_i & src_pc_i) | ~src_pc_en_i)),
        pd: (pins_o_i.pd_oe & pins_o_i.pd) | ~pins_o_i.pd_oe,
        pe: src_pe_i};
endmodule

// >>> test_pio_ports.sv
// Testbench for the parallel I/O ports through Wishbone and the pins.
// Assumes the board model resolves pin levels; one 200 MHz clock.
`timescale 1ns/1ps
module test_pio_ports;
    localparam logic [15:0] A_PA = 16'h4000, A_AD = 16'h4004, A_PB = 16'h4010;
    localparam logic [15:0] A_PC = 16'h4018, A_CD = 16'h401c, A_PD = 16'h4020;
    localparam logic [15:0] A_DD = 16'h4024, A_PE = 16'h4028, A_CT = 16'h4040;
    logic                    clk, rst, cyc, stb, we, ack, err, mode_exp;
    logic                    tcc_wr, tcc_pass, cap4, pacc, ss, rxd;
    logic [15:0]             adr;
    logic [3:0]              sel;
    logic [31:0]             wdat, rdat;
    logic [2:0]              cap, spi_pin;
    logic [7:0]              an, src_pa, src_pc, src_pc_en, src_pe, q;
    logic                    e;
    pio_pkg::pio_pin_in_t    pin_in;
    pio_pkg::pio_pin_out_t   pin_out;
    pio_pkg::pio_periph_in_t per;
    int                      n_errors, check_count;

    pio_ports i_pio_ports (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .wb_err_o(err), .mode_expanded_i(mode_exp), .pins_i(pin_in),
        .pins_o(pin_out), .periph_i(per), .tcc_write_i(tcc_wr), .tcc_write_o(tcc_pass),
        .capture_o(cap), .capture4_o(cap4), .pulse_accum_o(pacc), .spi_ss_o(ss),
        .spi_pin_o(spi_pin), .sci_rx_o(rxd), .analog_pin_o(an));

    pio_board i_pio_board (
        .pins_o_i(pin_out), .src_pa_i(src_pa), .src_pc_i(src_pc),
        .src_pc_en_i(src_pc_en), .src_pe_i(src_pe), .pins_i_o(pin_in));

    ////////////////////////////////////////////////////////////////////////
    // Clock, half period 2.5 ns
    always #2.5 clk = ~clk;

    // Value compare
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Classic single cycle; waits for ack or err, bounded
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= 4'hf;
        wdat <= {24'h0, d};
        do begin
            @(posedge clk);
            n++;
        end while (!(ack === 1'b1 || err === 1'b1) && n < 40);
        if (n >= 40) n_errors++;
        q = rdat[7:0];
        e = err;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        sel <= 4'h0;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    // Read that must be answered by ack with the given byte
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk({7'h0, e}, 8'h00);
        chk(q, exp);
    endtask

    // Access that must be answered by err
    task automatic rd_err(input logic [15:0] a);
        bus(1'b0, a, 8'h00);
        chk({7'h0, e}, 8'h01);
    endtask

    // Two-stage pin sync plus margin
    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic report_and_stop();
        $display("checks=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog; the whole sequence needs well under 1000 cycles
    initial begin
        repeat (4000) @(posedge clk);
        n_errors++;
        report_and_stop();
    end

    // Main sequence
    initial begin
        clk = 1'b0; rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 16'h0;
        wdat = 32'h0; mode_exp = 1'b0; tcc_wr = 1'b0; per = '0; src_pa = 8'h3c;
        src_pc = 8'h00; src_pc_en = 8'h00; src_pe = 8'ha5; n_errors = 0; check_count = 0;
        sel = 4'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        rd(A_PB, 8'h00);
        rd(A_CD, 8'h00);
        rd(A_DD, 8'h00);
        chk(pin_out.pc_oe, 8'h00);
        chk({2'b00, pin_out.pd_oe}, 8'h00);
        $display("test reset done");
        // Latch holds the level seen on the pins during reset
        wr(A_AD, 8'hff);
        rd(A_PA, 8'h3c);
        src_pa <= 8'h5a;
        wr(A_AD, 8'h0f);
        wr(A_PA, 8'h33);
        settle();
        rd(A_PA, 8'h53);
        chk(pin_out.pa_oe, 8'h0f);
        chk({5'h0, cap}, 8'h03);
        wr(A_AD, 8'h8f);
        wr(A_PA, 8'h80);
        settle();
        chk({7'h0, pacc}, 8'h01);
        wr(A_PA, 8'h00);
        settle();
        chk({7'h0, pacc}, 8'h00);
        $display("test port a done");
        // Shared capture/compare and bit 3 function
        tcc_wr <= 1'b1;
        settle();
        chk({7'h0, tcc_pass}, 8'h01);
        wr(A_CT, 8'h01);
        chk({7'h0, tcc_pass}, 8'h00);
        wr(A_AD, 8'h08);
        wr(A_PA, 8'h08);
        settle();
        chk({7'h0, cap4}, 8'h01);
        wr(A_PA, 8'h00);
        settle();
        chk({7'h0, cap4}, 8'h00);
        wr(A_AD, 8'h00);
        per.oc_en <= 8'h08;
        per.oc_val <= 8'h08;
        settle();
        chk(pin_out.pa_oe, 8'h00);
        wr(A_CT, 8'h00);
        chk(pin_out.pa_oe, 8'h08);
        chk(pin_out.pa & pin_out.pa_oe, 8'h08);
        per.oc_en <= 8'h00;
        tcc_wr <= 1'b0;
        $display("test capture done");
        // Port C wired-OR in single-chip mode
        wr(A_CT, 8'h02);
        wr(A_CD, 8'hff);
        wr(A_PC, 8'h0f);
        chk(pin_out.pc_oe, 8'hf0);
        chk(pin_out.pc & pin_out.pc_oe, 8'h00);
        // Expanded mode: address and data bus take over B and C
        per.ext_addr_hi <= 8'hc3;
        per.ext_data <= 8'h96;
        per.ext_write <= 1'b1;
        mode_exp <= 1'b1;
        settle();
        chk(pin_out.pb, 8'hc3);
        chk(pin_out.pc_oe, 8'hff);
        chk(pin_out.pc, 8'h96);
        rd_err(A_PB);
        rd_err(A_PC);
        per.ext_write <= 1'b0;
        settle();
        chk(pin_out.pc_oe, 8'h00);
        mode_exp <= 1'b0;
        wr(A_CT, 8'h00);
        settle();
        wr(A_PB, 8'h5c);
        chk(pin_out.pb, 8'h5c);
        rd_err(16'h4100);
        $display("test ports b c done");
        // Port D: general use, wired-OR, SPI master and slave
        wr(A_DD, 8'h3f);
        wr(A_PD, 8'h2a);
        chk({2'b00, pin_out.pd_oe}, 8'h3f);
        per.spi_od <= 1'b1;
        settle();
        chk({2'b00, pin_out.pd_oe}, 8'h15);
        per.spi_od <= 1'b0;
        per.spi_en <= 1'b1;
        per.spi_master <= 1'b1;
        per.spi_val <= 3'h4;
        settle();
        chk({2'b00, pin_out.pd_oe}, 8'h3b);
        chk({2'b00, pin_out.pd & pin_out.pd_oe}, 8'h32);
        chk({5'h0, spi_pin}, 8'h05);
        chk({7'h0, rxd}, 8'h00);
        per.spi_master <= 1'b0;
        settle();
        chk({2'b00, pin_out.pd_oe}, 8'h07);
        per.spi_master <= 1'b1;
        wr(A_DD, 8'h00);
        settle();
        chk({2'b00, pin_out.pd_oe}, 8'h00);
        chk({7'h0, ss}, 8'h01);
        per.sci_tx_en <= 1'b1;
        settle();
        chk({2'b00, pin_out.pd_oe}, 8'h02);
        chk({7'h0, pin_out.pd[1]}, 8'h00);
        chk({7'h0, rxd}, 8'h01);
        per.spi_en <= 1'b0;
        per.sci_tx_en <= 1'b0;
        $display("test port d done");
        // Port E, read with no conversion sampling under way
        rd(A_PE, 8'ha5);
        wr(A_PE, 8'h00);
        rd(A_PE, 8'ha5);
        chk(an, 8'ha5);
        $display("test port e done");
        report_and_stop();
    end
endmodule
